// ===== bench/vde_dma_model.sv
// dma controller model: apb master and sync event counters
`timescale 1ns/1ps
module vde_dma_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // apb master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // sync events
  input wire logic transmitSyncEvent,
  input wire logic receiveSyncEvent
);
  logic [7:0] xCnt;
  logic [7:0] rCnt;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      xCnt <= 8'h00;
      rCnt <= 8'h00;
    end
    else
    begin
      xCnt <= xCnt + 8'(transmitSyncEvent);
      rCnt <= rCnt + 8'(receiveSyncEvent);
    end
  end
  // one apb transfer; answer taken at the rising edge that sees pready high, released after it
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule // vde_dma_model

// ===== bench/vde_event_port_tb.sv
// self-checking bench of the viterbi dma event port
`timescale 1ns/1ps
`include "vde_cfg.svh"
module vde_event_port_tb;
  logic mclk, rstn, psel, penable, pwrite, pready, pslverr, xev, rev, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  vde_event_port i_dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .transmitSyncEvent(xev), .receiveSyncEvent(rev));
  vde_dma_model i_dma (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .transmitSyncEvent(xev), .receiveSyncEvent(rev));
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_dma.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    i_dma.xfer(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, 32'h0);
  endtask
  // six config words; polynomials and metrics fixed, the rest per channel
  task automatic cfg6(input logic [31:0] c1, input logic [31:0] c2, input logic [31:0] c3, input logic [31:0] c5);
    wr(`VDE_ADDR_IC0, 32'h0000_0a0c);
    wr(`VDE_ADDR_IC1, c1);
    wr(`VDE_ADDR_IC2, c2);
    wr(`VDE_ADDR_IC3, c3);
    wr(`VDE_ADDR_IC4, 32'h0064_1ffb);
    wr(`VDE_ADDR_IC5, c5);
  endtask
  // wait, bounded, for the event count to reach n
  task automatic waitev(input logic rx, input logic [7:0] n);
    for (int i = 0; i < 400 && (rx ? i_dma.rCnt : i_dma.xCnt) < n; i++)
      @(negedge mclk);
    chk({24'h0, rx ? i_dma.rCnt : i_dma.xCnt}, {24'h0, n});
  endtask
  initial
  begin
    rstn = 1'b0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(`VDE_ADDR_STAT, 32'h0);
    i_dma.xfer(1'b0, 12'h0fc, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    wr(`VDE_ADDR_EXE, `VDE_EXE_START);
    waitev(1'b0, 8'd1);
    wr(`VDE_ADDR_IC0, 32'h0000_0a0c);
    rd(`VDE_ADDR_IC0, 32'h0101_0b0d);
    wr(`VDE_ADDR_IC1, 32'h0000_0032);
    wr(`VDE_ADDR_IC2, 32'h0000_0064);
    wr(`VDE_ADDR_IC3, 32'h0);
    wr(`VDE_ADDR_IC4, 32'h0064_1ffb);
    wr(`VDE_ADDR_IC5, 32'h0201_0107);
    waitev(1'b0, 8'd2);
    for (int a = 0; a < 4; a++)
    begin
      for (int w = 0; w < 16; w++)
        wr(`VDE_ADDR_BMPORT, 32'(a * 16 + w));
      if (a < 3)
        waitev(1'b0, 8'(a + 3));
    end
    waitev(1'b1, 8'd1);
    for (int w = 0; w < 4; w++)
      i_dma.xfer(1'b0, `VDE_ADDR_DECPORT, 32'h0, q, e);
    waitev(1'b1, 8'd2);
    chk({24'h0, i_dma.xCnt}, 32'd5);
    rd(`VDE_ADDR_OUT0, 32'h1ffb_0064);
    rd(`VDE_ADDR_OUT1, 32'h0000_0002);
    waitev(1'b0, 8'd6);
    // second channel: convergent, soft, 16 words per event, no output params
    cfg6(32'h0000_0032, 32'h0000_0020, 32'h0000_0060, 32'h010c_010f);
    waitev(1'b0, 8'd7);
    for (int a = 0; a < 2; a++)
    begin
      for (int w = 0; w < 32; w++)
        wr(`VDE_ADDR_BMPORT, 32'(w));
      if (a == 0)
        waitev(1'b0, 8'd8);
    end
    waitev(1'b1, 8'd4);
    for (int w = 0; w < 8; w++)
      i_dma.xfer(1'b0, `VDE_ADDR_DECPORT, 32'h0, q, e);
    waitev(1'b0, 8'd9);
    chk({24'h0, i_dma.rCnt}, 32'd4);
    rd(`VDE_ADDR_OUT1, 32'h0000_0001);
    // a rate of zero is refused: error state, no transmit event
    cfg6(32'h0, 32'h0000_0020, 32'h0000_0060, 32'h010c_010f);
    rd(`VDE_ADDR_STAT, 32'h0000_0004);
    chk({24'h0, i_dma.xCnt}, 32'd9);
    wr(`VDE_ADDR_EXE, `VDE_EXE_START);
    waitev(1'b0, 8'd10);
    test_done();
  end
endmodule // vde_event_port_tb

// ===== logic/vde_buf_mem.sv
// two-port buffer memory with registered read data
`timescale 1ns/1ps
module vde_buf_mem #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32
) (
  // clock
  input wire logic mclk,
  // write port
  input wire logic wrEn,
  input wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  // read port
  input wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge mclk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge mclk)
  begin
    rdData <= mem[rdAddr];
  end
endmodule // vde_buf_mem

// ===== logic/vde_cfg.svh
// offsets, fields, reset values and codes of the viterbi dma event port
`ifndef VDE_CFG_SVH
`define VDE_CFG_SVH
`define VDE_ADDR_IC0 12'h000
`define VDE_ADDR_IC1 12'h004
`define VDE_ADDR_IC2 12'h008
`define VDE_ADDR_IC3 12'h00c
`define VDE_ADDR_IC4 12'h010
`define VDE_ADDR_IC5 12'h014
`define VDE_ADDR_EXE 12'h018
`define VDE_ADDR_OUT0 12'h01c
`define VDE_ADDR_OUT1 12'h020
`define VDE_ADDR_STAT 12'h024
`define VDE_ADDR_BMPORT 12'h040
`define VDE_ADDR_DECPORT 12'h044
`define VDE_EXE_START 32'h0000_0001
`define VDE_POLY_LSB_SET 32'h0101_0101
`define VDE_CFG_ALL 6'h3f
`define VDE_TB_CONV 2'h2
`define VDE_METRIC_MOST_NEG 13'h1000
`define VDE_METRIC_MOST_POS 13'h0fff
`define VDE_WORD_BYTES 20'h0_0008
`endif

// ===== logic/vde_event_port.sv
// viterbi decoder dma event port: config, double-buffered fifos, sync events
//
// What this block does
// - tailed or mixed traceback: total metric bytes are (F+K-1)*2^(r-1)
// - convergent traceback: total metric bytes are (F+C)*2^(r-1)
// - polynomials come bit-reversed and the device forces their lsb
// - selected state starts at max metric, all others at min metric
// - initial max and min metrics are 13-bit signed values
// - output-params flag decides on the extra receive event
// - final max, min metric and max state index appear in output registers
// - start command raises a transmit event
// - all config words received and valid raise a transmit event
// - an empty input half raises a transmit event while metrics remain
// - final transmit event after decisions, and output registers if flagged
// - each filled output half raises a receive event
// - end of traceback raises a receive event for the rest
// - flag set and decisions read raise a receive event for outputs
// - each receive event covers (output transfers+1) 64-bit words
// - each transmit event brings 8 or 16 64-bit words
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "vde_cfg.svh"
module vde_event_port #(
  parameter int IN_HALF_WORDS = 16,
  parameter int OUT_HALF_WORDS = 32,
  parameter int IDX_W = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // dma synchronisation events
  output logic transmitSyncEvent,
  output logic receiveSyncEvent
);
  localparam int IN_AW = $clog2(2 * IN_HALF_WORDS);
  localparam int OUT_AW = $clog2(2 * OUT_HALF_WORDS);

  if (IN_HALF_WORDS < 16 || OUT_HALF_WORDS < 32 || IDX_W < 8)
  begin : g_chk
    $error("vde_event_port: buffers or index too small for the documented ranges");
  end

  // ***************************************************************
  // reset release and apb decode
  // ***************************************************************
  logic rstMeta_q, rstnSync;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rstMeta_q <= 1'b0;
      rstnSync <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstnSync <= rstMeta_q;
    end
  end

  logic wrAcc, rdAcc;
  assign pready = 1'b1;
  assign wrAcc = psel && penable && pwrite;
  assign rdAcc = psel && penable && !pwrite;

  // ***************************************************************
  // configuration words and control state
  // ***************************************************************
  vde_pkg::vde_state_t state_q;
  logic [31:0] ic_q [6];
  logic [5:0] cfgSeen_q;
  vde_pkg::vde_cfg_t cfg;
  logic cfgOk, symxOk, startCmd, out1Read, decAllRead;

  always_comb
  begin
    cfg.polys = ic_q[0];
    cfg.rateInv = ic_q[1][3:0];
    cfg.constraintLen = ic_q[1][7:4];
    cfg.frameLen = ic_q[2][15:0];
    cfg.convLen = ic_q[3][15:0];
    cfg.minMetricInit = ic_q[4][12:0];
    cfg.maxMetricInit = ic_q[4][28:16];
    cfg.inputTransfersPerEvent = ic_q[5][3:0];
    cfg.outputTransfersPerEvent = ic_q[5][12:8];
    cfg.outputParamsFlag = ic_q[5][16];
    cfg.tracebackMode = ic_q[5][18:17];
    cfg.softDecisions = ic_q[5][19];
    cfg.maxStateIndexInit = ic_q[5][31:24];
  end

  // accepted transfer counts per rate, all giving 8 or 16 words per event
  assign symxOk = (cfg.rateInv == 4'h4 && (cfg.inputTransfersPerEvent == 4'h3 || cfg.inputTransfersPerEvent == 4'h1))
               || (cfg.rateInv == 4'h3 && (cfg.inputTransfersPerEvent == 4'h7 || cfg.inputTransfersPerEvent == 4'h3))
               || (cfg.rateInv == 4'h2 && (cfg.inputTransfersPerEvent == 4'hf || cfg.inputTransfersPerEvent == 4'h7));
  assign cfgOk = symxOk && cfg.frameLen != 16'h0000 && cfg.outputTransfersPerEvent != 5'h00
              && cfg.constraintLen >= 4'h3 && cfg.constraintLen <= 4'h9
              && 9'(cfg.maxStateIndexInit) < (9'h001 << (cfg.constraintLen - 4'h1))
              && !(cfg.rateInv == 4'h2 && cfg.polys[31:16] != 16'h0101)
              && !(cfg.rateInv == 4'h3 && cfg.polys[31:24] != 8'h01);

  assign startCmd = wrAcc && paddr == `VDE_ADDR_EXE && pwdata == `VDE_EXE_START
                 && (state_q == vde_pkg::VDE_IDLE || state_q == vde_pkg::VDE_ERR);
  assign out1Read = rdAcc && paddr == `VDE_ADDR_OUT1;

  always_ff @(posedge mclk or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      for (int i = 0; i < 6; i++)
      begin
        ic_q[i] <= 32'h0000_0000;
      end
      cfgSeen_q <= 6'h00;
    end
    else if (state_q == vde_pkg::VDE_CFG && wrAcc && paddr <= `VDE_ADDR_IC5 && paddr[1:0] == 2'h0)
    begin
      // polynomial lsb is set here whatever software sent
      ic_q[paddr[4:2]] <= (paddr == `VDE_ADDR_IC0) ? (pwdata | `VDE_POLY_LSB_SET) : pwdata;
      cfgSeen_q[paddr[4:2]] <= 1'b1;
    end
    else if (state_q != vde_pkg::VDE_CFG)
    begin
      cfgSeen_q <= 6'h00;
    end
  end

  always_ff @(posedge mclk or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      state_q <= vde_pkg::VDE_IDLE;
    end
    else
    begin
      case (state_q)
        vde_pkg::VDE_IDLE, vde_pkg::VDE_ERR: if (startCmd) state_q <= vde_pkg::VDE_CFG;
        vde_pkg::VDE_CFG: if (cfgSeen_q == `VDE_CFG_ALL) state_q <= cfgOk ? vde_pkg::VDE_RUN : vde_pkg::VDE_ERR;
        vde_pkg::VDE_RUN:
          if (decAllRead)
          begin
            state_q <= cfg.outputParamsFlag ? vde_pkg::VDE_OUTP : vde_pkg::VDE_CFG;
          end
        vde_pkg::VDE_OUTP: if (out1Read) state_q <= vde_pkg::VDE_CFG;
        default: state_q <= vde_pkg::VDE_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // input side: branch metric fifo halves
  // ***************************************************************
  logic runEntry;
  logic [9:0] arrayBytes;
  logic [6:0] wordsPerEvt;
  logic [19:0] total_branch_metric_bytes, outBytesTotal, bmLeft_q, outLeft_q;
  logic [1:0] inFull_q, outFull_q;
  logic inWrHalf_q, inRdHalf_q, outstanding_q, bmHi_q, bmEvt, fillDone;
  logic [31:0] bmLo_q;
  logic [IN_AW-2:0] inWrIdx_q, inRdIdx_q;
  logic bmWrite, consume, consumeDone, inputDone;
  logic [63:0] inDout;

  assign runEntry = state_q == vde_pkg::VDE_CFG && cfgSeen_q == `VDE_CFG_ALL && cfgOk;
  assign arrayBytes = 10'(({6'h00, cfg.inputTransfersPerEvent} + 10'h001) << (cfg.rateInv + 4'h1));
  assign wordsPerEvt = arrayBytes[9:3];
  assign total_branch_metric_bytes = (cfg.tracebackMode == `VDE_TB_CONV)
    ? 20'(({4'h0, cfg.frameLen} + {4'h0, cfg.convLen}) << (cfg.rateInv - 4'h1))
    : 20'(({4'h0, cfg.frameLen} + {16'h0000, cfg.constraintLen} - 20'h00001) << (cfg.rateInv - 4'h1));
  // hard decisions pack eight bits a byte, soft give one byte per bit
  assign outBytesTotal = cfg.softDecisions ? {4'h0, cfg.frameLen} : {7'h00, cfg.frameLen[15:3]};

  assign bmWrite = wrAcc && paddr == `VDE_ADDR_BMPORT && state_q == vde_pkg::VDE_RUN && !inFull_q[inWrHalf_q];
  assign fillDone = bmWrite && bmHi_q && 7'(inWrIdx_q) == wordsPerEvt - 7'h01;
  // first run cycle finds both halves empty and asks for the first array
  assign bmEvt = state_q == vde_pkg::VDE_RUN && !outstanding_q && bmLeft_q != 20'h00000
              && !inFull_q[inWrHalf_q];
  assign inputDone = bmLeft_q == 20'h00000 && !outstanding_q && inFull_q == 2'b00;

  always_ff @(posedge mclk or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      bmLeft_q <= 20'h00000;
      outstanding_q <= 1'b0;
      inWrHalf_q <= 1'b0;
      inWrIdx_q <= '0;
      bmHi_q <= 1'b0;
      bmLo_q <= 32'h0000_0000;
    end
    else if (runEntry)
    begin
      bmLeft_q <= total_branch_metric_bytes;
      outstanding_q <= 1'b0;
      inWrHalf_q <= 1'b0;
      inWrIdx_q <= '0;
      bmHi_q <= 1'b0;
    end
    else
    begin
      if (bmEvt)
      begin
        bmLeft_q <= (bmLeft_q > {10'h000, arrayBytes}) ? bmLeft_q - {10'h000, arrayBytes} : 20'h00000;
        outstanding_q <= 1'b1;
      end
      else if (fillDone)
      begin
        outstanding_q <= 1'b0;
      end
      if (bmWrite)
      begin
        // low word first, second write completes the 64-bit entry
        bmHi_q <= !bmHi_q;
        bmLo_q <= bmHi_q ? bmLo_q : pwdata;
        if (bmHi_q)
        begin
          inWrIdx_q <= fillDone ? '0 : inWrIdx_q + 1'b1;
          inWrHalf_q <= inWrHalf_q ^ fillDone;
        end
      end
    end
  end

  vde_buf_mem #(.WIDTH(64), .DEPTH(2 * IN_HALF_WORDS)) u_inMem (
    .mclk(mclk),
    .wrEn(bmWrite && bmHi_q),
    .wrAddr({inWrHalf_q, inWrIdx_q}),
    .wrData({pwdata, bmLo_q}),
    .rdAddr({inRdHalf_q, inRdIdx_q}),
    .rdData(inDout)
  );

  // ***************************************************************
  // decoding stand-in and output fifo halves
  // ***************************************************************
  logic outWrHalf_q, outRdHalf_q, pendWr_q, pendTail_q, decHi_q, produce, produceTail, outClose, decRead;
  logic [OUT_AW-2:0] outWrIdx_q, outRdIdx_q, pendIdx_q;
  logic [OUT_AW-2:0] outHalfLast_q [2];
  logic pendHalf_q;
  logic [63:0] acc_q, decWrData, decDout;
  logic decRdLast;

  assign consume = state_q == vde_pkg::VDE_RUN && inFull_q[inRdHalf_q]
                && (outLeft_q == 20'h00000 || !outFull_q[outWrHalf_q]);
  assign consumeDone = consume && 7'(inRdIdx_q) == wordsPerEvt - 7'h01;
  // traceback tail: input gone, decisions still owed
  assign produceTail = state_q == vde_pkg::VDE_RUN && inputDone && outLeft_q != 20'h00000 && !outFull_q[outWrHalf_q];
  assign produce = (consume && outLeft_q != 20'h00000) || produceTail;
  assign outClose = produce && ({1'b0, outWrIdx_q} == 6'(cfg.outputTransfersPerEvent)
                 || outLeft_q <= `VDE_WORD_BYTES);
  assign decWrData = pendTail_q ? acc_q : (inDout ^ acc_q ^ {cfg.polys, cfg.polys});
  assign decRead = rdAcc && paddr == `VDE_ADDR_DECPORT && outFull_q[outRdHalf_q];
  assign decRdLast = decRead && decHi_q && outRdIdx_q == outHalfLast_q[outRdHalf_q];

  always_ff @(posedge mclk or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      inRdHalf_q <= 1'b0;
      inRdIdx_q <= '0;
      outLeft_q <= 20'h00000;
      outWrHalf_q <= 1'b0;
      outWrIdx_q <= '0;
      pendWr_q <= 1'b0;
      pendTail_q <= 1'b0;
      pendHalf_q <= 1'b0;
      pendIdx_q <= '0;
      acc_q <= 64'h0;
      outHalfLast_q[0] <= '0;
      outHalfLast_q[1] <= '0;
    end
    else if (runEntry)
    begin
      inRdHalf_q <= 1'b0;
      inRdIdx_q <= '0;
      outLeft_q <= outBytesTotal;
      outWrHalf_q <= 1'b0;
      outWrIdx_q <= '0;
      pendWr_q <= 1'b0;
      acc_q <= 64'h0;
    end
    else
    begin
      if (consume)
      begin
        inRdIdx_q <= consumeDone ? '0 : inRdIdx_q + 1'b1;
        inRdHalf_q <= inRdHalf_q ^ consumeDone;
      end
      pendWr_q <= produce;
      pendTail_q <= produceTail;
      pendHalf_q <= outWrHalf_q;
      pendIdx_q <= outWrIdx_q;
      if (pendWr_q)
      begin
        acc_q <= decWrData;
      end
      if (produce)
      begin
        outLeft_q <= (outLeft_q > `VDE_WORD_BYTES) ? outLeft_q - `VDE_WORD_BYTES : 20'h00000;
        outWrIdx_q <= outClose ? '0 : outWrIdx_q + 1'b1;
        outWrHalf_q <= outWrHalf_q ^ outClose;
        if (outClose)
        begin
          outHalfLast_q[outWrHalf_q] <= outWrIdx_q;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      inFull_q <= 2'b00;
      outFull_q <= 2'b00;
    end
    else if (runEntry)
    begin
      inFull_q <= 2'b00;
      outFull_q <= 2'b00;
    end
    else
    begin
      // filling wins over draining when both hit one half
      for (int h = 0; h < 2; h++)
      begin
        if (fillDone && inWrHalf_q == h[0])
          inFull_q[h] <= 1'b1;
        else if (consumeDone && inRdHalf_q == h[0])
          inFull_q[h] <= 1'b0;
        if (outClose && outWrHalf_q == h[0])
          outFull_q[h] <= 1'b1;
        else if (decRdLast && outRdHalf_q == h[0])
          outFull_q[h] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      outRdHalf_q <= 1'b0;
      outRdIdx_q <= '0;
      decHi_q <= 1'b0;
    end
    else if (runEntry)
    begin
      outRdHalf_q <= 1'b0;
      outRdIdx_q <= '0;
      decHi_q <= 1'b0;
    end
    else if (decRead)
    begin
      decHi_q <= !decHi_q;
      if (decHi_q)
      begin
        outRdIdx_q <= decRdLast ? '0 : outRdIdx_q + 1'b1;
        outRdHalf_q <= outRdHalf_q ^ decRdLast;
      end
    end
  end

  vde_buf_mem #(.WIDTH(64), .DEPTH(2 * OUT_HALF_WORDS)) u_outMem (
    .mclk(mclk),
    .wrEn(pendWr_q),
    .wrAddr({pendHalf_q, pendIdx_q}),
    .wrData(decWrData),
    .rdAddr({outRdHalf_q, outRdIdx_q}),
    .rdData(decDout)
  );

  // ***************************************************************
  // final metrics scan
  // ***************************************************************
  logic [IDX_W:0] scanIdx_q, nStates;
  logic signed [12:0] curMetric, fMax_q, fMin_q;
  logic [IDX_W-1:0] fMaxIdx_q;
  logic scanDone;

  assign nStates = (IDX_W + 1)'(1) << (cfg.constraintLen - 4'h1);
  assign scanDone = scanIdx_q >= nStates;

  vde_metric_init #(.IDX_W(IDX_W)) u_metric (
    .stateIdx(scanIdx_q[IDX_W-1:0]),
    .maxStateIndexInit(cfg.maxStateIndexInit),
    .maxMetricInit(cfg.maxMetricInit),
    .minMetricInit(cfg.minMetricInit),
    .metric(curMetric)
  );

  always_ff @(posedge mclk or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      scanIdx_q <= '0;
      fMax_q <= `VDE_METRIC_MOST_NEG;
      fMin_q <= `VDE_METRIC_MOST_POS;
      fMaxIdx_q <= '0;
    end
    else if (runEntry)
    begin
      scanIdx_q <= '0;
      fMax_q <= `VDE_METRIC_MOST_NEG;
      fMin_q <= `VDE_METRIC_MOST_POS;
    end
    else if (state_q == vde_pkg::VDE_RUN && !scanDone)
    begin
      // signed compare, metrics are 13-bit two's complement
      if (curMetric > fMax_q || scanIdx_q == '0)
      begin
        fMax_q <= curMetric;
        fMaxIdx_q <= scanIdx_q[IDX_W-1:0];
      end
      if (curMetric < fMin_q)
      begin
        fMin_q <= curMetric;
      end
      scanIdx_q <= scanIdx_q + 1'b1;
    end
  end

  // ***************************************************************
  // events and read data
  // ***************************************************************
  assign decAllRead = state_q == vde_pkg::VDE_RUN && outLeft_q == 20'h00000 && outFull_q == 2'b00
                   && inputDone && scanDone && !pendWr_q;

  always_ff @(posedge mclk or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      transmitSyncEvent <= 1'b0;
      receiveSyncEvent <= 1'b0;
    end
    else
    begin
      transmitSyncEvent <= startCmd || bmEvt
        || (decAllRead && !cfg.outputParamsFlag) || (state_q == vde_pkg::VDE_OUTP && out1Read);
      receiveSyncEvent <= outClose || (decAllRead && cfg.outputParamsFlag);
    end
  end

  always_comb
  begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    case (paddr)
      `VDE_ADDR_IC0, `VDE_ADDR_IC1, `VDE_ADDR_IC2, `VDE_ADDR_IC3, `VDE_ADDR_IC4, `VDE_ADDR_IC5:
        prdata = ic_q[paddr[4:2]];
      `VDE_ADDR_OUT0: prdata = {3'h0, fMin_q, 3'h0, fMax_q};
      `VDE_ADDR_OUT1: prdata = {{(32 - IDX_W){1'b0}}, fMaxIdx_q};
      `VDE_ADDR_STAT: prdata = {20'h00000, inFull_q, outFull_q, inWrHalf_q, outRdHalf_q, 3'h0, state_q};
      `VDE_ADDR_DECPORT: prdata = decHi_q ? decDout[63:32] : decDout[31:0];
      `VDE_ADDR_EXE, `VDE_ADDR_BMPORT: prdata = 32'h0000_0000;
      default: pslverr = psel && penable;
    endcase
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstnSync);

  start_event_a: assert property (startCmd |=> transmitSyncEvent && state_q == vde_pkg::VDE_CFG)
    else $error("start did not raise a transmit event");
  cfg_error_a: assert property (state_q == vde_pkg::VDE_CFG && cfgSeen_q == `VDE_CFG_ALL && !cfgOk
    |=> state_q == vde_pkg::VDE_ERR && !transmitSyncEvent)
    else $error("bad config was not refused");
  cfg_first_evt_a: assert property (runEntry |=> ##1 transmitSyncEvent)
    else $error("valid config did not raise a transmit event");
  bm_empty_half_a: assert property (bmEvt |-> !inFull_q[inWrHalf_q] ##1 transmitSyncEvent)
    else $error("transmit event with no empty half");
  event_pulse_a: assert property (transmitSyncEvent && state_q == vde_pkg::VDE_RUN |=> !transmitSyncEvent)
    else $error("transmit event longer than one cycle");
  rx_half_full_a: assert property (outClose |=> receiveSyncEvent && outFull_q[$past(outWrHalf_q)])
    else $error("filled output half without receive event");
  outp_event_a: assert property (decAllRead && cfg.outputParamsFlag
    |=> receiveSyncEvent && state_q == vde_pkg::VDE_OUTP)
    else $error("output params receive event missing");
  final_xevt_a: assert property (state_q == vde_pkg::VDE_OUTP && out1Read
    |=> transmitSyncEvent && state_q == vde_pkg::VDE_CFG)
    else $error("next channel transmit event missing");
  poly_lsb_a: assert property (state_q == vde_pkg::VDE_RUN |-> (ic_q[0] & `VDE_POLY_LSB_SET) == `VDE_POLY_LSB_SET)
    else $error("polynomial lsb not forced");
  init_metric_a: assert property (state_q == vde_pkg::VDE_RUN && scanDone
    |-> fMax_q == cfg.maxMetricInit && fMaxIdx_q == cfg.maxStateIndexInit)
    else $error("final max does not match initial selection");

  start_run_c: cover property (state_q == vde_pkg::VDE_CFG ##1 state_q == vde_pkg::VDE_RUN);
  half_swap_c: cover property (fillDone && inWrHalf_q);
  outp_path_c: cover property (state_q == vde_pkg::VDE_OUTP ##[1:40] state_q == vde_pkg::VDE_CFG);
  cfg_err_c: cover property (state_q == vde_pkg::VDE_ERR);
endmodule // vde_event_port

// ===== logic/vde_metric_init.sv
// initial state metric of one trellis state
`timescale 1ns/1ps
module vde_metric_init #(
  parameter int IDX_W = 8
) (
  // state selection
  input wire logic [IDX_W-1:0] stateIdx,
  input wire logic [IDX_W-1:0] maxStateIndexInit,
  // signed 13-bit metrics
  input wire logic signed [12:0] maxMetricInit,
  input wire logic signed [12:0] minMetricInit,
  output logic signed [12:0] metric
);
  // the one selected state starts high, all others low
  assign metric = (stateIdx == maxStateIndexInit) ? maxMetricInit : minMetricInit;
endmodule // vde_metric_init

// ===== logic/vde_pkg.sv
// types shared by the viterbi dma event port
package vde_pkg;
  typedef enum logic [2:0] {VDE_IDLE, VDE_CFG, VDE_RUN, VDE_OUTP, VDE_ERR} vde_state_t;
  typedef struct packed {
    logic [31:0] polys;
    logic [3:0] rateInv;
    logic [3:0] constraintLen;
    logic [15:0] frameLen;
    logic [15:0] convLen;
    logic signed [12:0] minMetricInit;
    logic signed [12:0] maxMetricInit;
    logic [3:0] inputTransfersPerEvent;
    logic [4:0] outputTransfersPerEvent;
    logic outputParamsFlag;
    logic [1:0] tracebackMode;
    logic softDecisions;
    logic [7:0] maxStateIndexInit;
  } vde_cfg_t;
endpackage
